/* File: hdl/csd_top.v */
// Purpose: peripheral/upper/lower selects and DRAM row/column strobes
// Assumes: bus cycle shown by i_addr_valid (address phase) then i_data_phase
// Notes:   select and column strobe pins use o_*_oe_n low while driving
//          no refresh, page mode or row/column address mux here
//          base and size stored raw; the 512K clamp is in decode
`include "csd_consts.vh"
`default_nettype none
module csd_top (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_nrst,
    // Processor bus cycle
    input  wire        i_addr_valid,   // Address phase on separate address bus
    input  wire        i_data_phase,   // Multiplexed bus data phase
    input  wire        i_is_mem,       // 1 memory, 0 I/O
    input  wire [19:0] i_addr,
    input  wire        i_write_low_byte,
    input  wire        i_write_high_byte,
    input  wire        i_read,
    input  wire        i_bus_hold,     // Another master owns the bus
    // Strap pin
    input  wire        i_upper_select_byte_width_strap,
    // Register port
    input  wire [3:0]  i_reg_addr,
    input  wire [15:0] i_reg_wdata,
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    output reg  [15:0] o_reg_rdata,
    // Peripheral selects
    output reg  [7:0]  o_peripheral_select_n,
    output reg         o_peripheral_select_oe_n,
    // Upper memory select / upper row strobe
    output reg         o_upper_memory_select_n,
    output reg         o_upper_memory_select_oe_n,
    output reg         o_row_strobe_upper_n,
    // Lower select pin: select or lower row strobe
    output reg         o_lower_memory_select_n,
    output reg         o_lower_select_oe_n,
    // Column strobes
    output reg  [1:0]  o_column_strobe_n,
    output reg         o_column_strobe_oe_n,
    // Bus width of the current upper access
    output reg         o_upper_is_x8
);
    // ---------------------------------------------------------------
    // Decode helper
    // ---------------------------------------------------------------
    // Region hit on 4K units, size clamped to 512K
    // Nine-bit top so a block ending at FFFFFh does not wrap
    function in_region;
        input [19:0] addr;
        input [7:0]  base;
        input [7:0]  size;
        reg   [8:0]  top;
        reg   [7:0]  sz;
        begin
            sz = (size > `CSD_MAX_SIZE) ? `CSD_MAX_SIZE : size;
            top = {1'b0, base} + {1'b0, sz};
            in_region = ({1'b0, addr[19:12]} >= {1'b0, base}) &&
                        ({1'b0, addr[19:12]} < top);
        end
    endfunction

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    reg [15:0] per_base_r;   // Peripheral block base
    reg        per_mem_r;    // Peripheral block in memory space
    reg [7:0]  upr_base_r;   // Upper block base, 4K units
    reg [7:0]  upr_size_r;   // Upper block size, 4K units
    reg [7:0]  lwr_base_r;   // Lower block base
    reg [7:0]  lwr_size_r;   // Lower block size
    reg        upr_dram_r;   // Upper region is DRAM
    reg        lwr_dram_r;   // Lower region is DRAM
    reg        lwr_en_r;     // Lower region enabled
    reg        upr_x8_r;     // Upper width, loaded from strap
    reg [1:0]  strap_cnt_r;  // Edges since release, stops at 3
    wire       strap_done;   // Strap width has been taken
    wire       strap_s;      // Synchronised strap level
    wire       hold_s;       // Synchronised bus hold

    // Counting keeps the strap out until the synchroniser holds the pin
    assign strap_done = (strap_cnt_r == 2'h3);

    // Strap and hold come from pins, so synchronise them
    // Hold acts two edges after its pin, the pins one edge later
    csd_sync u_sync_strap (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_d    (i_upper_select_byte_width_strap),
        .o_q    (strap_s)
    );
    csd_sync u_sync_hold (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_d    (i_bus_hold),
        .o_q    (hold_s)
    );

    // ---------------------------------------------------------------
    // Register writes and strap capture
    // ---------------------------------------------------------------
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            per_base_r   <= `CSD_PER_BASE_RST;
            per_mem_r    <= 1'b0;
            upr_base_r   <= `CSD_UPR_BASE_RST;
            upr_size_r   <= `CSD_UPR_SIZE_RST;
            lwr_base_r   <= 8'h00;
            lwr_size_r   <= 8'h00;
            upr_dram_r   <= 1'b0;
            lwr_dram_r   <= 1'b0;
            lwr_en_r     <= 1'b0;
            upr_x8_r     <= 1'b0;
            strap_cnt_r  <= 2'h0;
        end else begin
            // Strap taken once, at the third edge after release: the
            // synchroniser shows its reset level for the first two
            if (!strap_done) begin
                strap_cnt_r <= strap_cnt_r + 2'h1;
            end
            if (strap_cnt_r == 2'h2) begin
                upr_x8_r <= strap_s;
            end
            if (i_reg_wr) begin
                case (i_reg_addr)
                    `CSD_REG_PER_BASE: per_base_r <= i_reg_wdata;
                    `CSD_REG_PER_CTRL: per_mem_r  <= i_reg_wdata[`CSD_PER_MEM_BIT];
                    `CSD_REG_UPR_BASE: upr_base_r <= i_reg_wdata[7:0];
                    `CSD_REG_UPR_SIZE: upr_size_r <= i_reg_wdata[7:0];
                    `CSD_REG_LWR_BASE: lwr_base_r <= i_reg_wdata[7:0];
                    `CSD_REG_LWR_SIZE: lwr_size_r <= i_reg_wdata[7:0];
                    `CSD_REG_MEM_CTRL: begin
                        upr_dram_r <= i_reg_wdata[`CSD_UPR_DRAM_BIT];
                        lwr_dram_r <= i_reg_wdata[`CSD_LWR_DRAM_BIT];
                        lwr_en_r   <= i_reg_wdata[`CSD_LWR_EN_BIT];
                        // Software override only once the strap is taken
                        if (strap_done) begin
                            upr_x8_r <= i_reg_wdata[`CSD_UPR_X8_BIT];
                        end
                    end
                    default: ;   // Unmapped writes ignored
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Register read, data one cycle after strobe
    // ---------------------------------------------------------------
    reg [15:0] rd_nxt;   // Read mux
    // Reads have no side effects, so a stray read is harmless
    always @* begin
        case (i_reg_addr)
            `CSD_REG_PER_BASE: rd_nxt = per_base_r;
            `CSD_REG_PER_CTRL: rd_nxt = {15'h0000, per_mem_r};
            `CSD_REG_UPR_BASE: rd_nxt = {8'h00, upr_base_r};
            `CSD_REG_UPR_SIZE: rd_nxt = {8'h00, upr_size_r};
            `CSD_REG_LWR_BASE: rd_nxt = {8'h00, lwr_base_r};
            `CSD_REG_LWR_SIZE: rd_nxt = {8'h00, lwr_size_r};
            `CSD_REG_MEM_CTRL: rd_nxt = {12'h000, lwr_en_r, upr_x8_r, lwr_dram_r, upr_dram_r};
            // Live strobe state, low active as on the pins
            `CSD_REG_STATUS:   rd_nxt = {3'h0, hold_s, o_column_strobe_n, o_row_strobe_upper_n,
                                         o_lower_memory_select_n, o_peripheral_select_n};
            default:           rd_nxt = 16'h0000;
        endcase
    end

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reg_rdata <= 16'h0000;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rd_nxt;
        end else begin
            // Zero between reads keeps a shared read bus quiet
            o_reg_rdata <= 16'h0000;   // Data stand for one cycle only
        end
    end

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    wire       upr_hit;      // Memory access in upper block
    wire       lwr_hit;      // Memory access in lower block
    wire       per_hit;      // Access inside peripheral block
    wire [2:0] per_idx;      // Which of the eight regions
    wire [19:0] per_off;     // Offset from block base

    // Upper beats lower beats peripheral: overlap is a software fault,
    // and priority still keeps a single select low at a time

    assign upr_hit = i_is_mem && in_region(i_addr, upr_base_r, upr_size_r);
    assign lwr_hit = i_is_mem && lwr_en_r && !upr_hit &&
                     in_region(i_addr, lwr_base_r, lwr_size_r);
    // Peripheral block: eight 128-byte regions above the base
    assign per_off = i_addr - (per_mem_r ? {per_base_r, 4'h0} : {4'h0, per_base_r});
    // Below the base per_off wraps high, so the limit test rejects it
    assign per_hit = (i_is_mem == per_mem_r) &&
                     (per_off < 20'h00400) && !upr_hit && !lwr_hit;
    assign per_idx = per_off[`CSD_PER_SHIFT+2:`CSD_PER_SHIFT];

    // ---------------------------------------------------------------
    // Strobe generation
    // ---------------------------------------------------------------
    // Memory selects follow the address phase; peripheral selects wait
    // for the data phase so they never glitch on a stale address.
    reg        upr_act_r;    // Upper access latched at address phase
    reg        lwr_act_r;    // Lower access latched at address phase
    reg        per_act_r;    // Peripheral access pending
    reg [2:0]  per_idx_r;    // Latched region
    reg [1:0]  byte_r;       // Latched byte writes
    reg        rd_r;         // Latched read

    // Latch on the address phase, clear on the first idle edge; a cycle
    // seen while hold is up is never latched, so no select is owed

    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            upr_act_r <= 1'b0;
            lwr_act_r <= 1'b0;
            per_act_r <= 1'b0;
            per_idx_r <= 3'h0;
            byte_r    <= 2'h0;
            rd_r      <= 1'b0;
        end else if (i_addr_valid && !hold_s) begin
            upr_act_r <= upr_hit;
            lwr_act_r <= lwr_hit;
            per_act_r <= per_hit;
            per_idx_r <= per_idx;
            byte_r    <= {i_write_high_byte, i_write_low_byte};
            rd_r      <= i_read;
        end else if (!i_data_phase) begin
            // Cycle over: drop everything but the latched region between accesses
            upr_act_r <= 1'b0;
            lwr_act_r <= 1'b0;
            per_act_r <= 1'b0;
            byte_r    <= 2'h0;
            rd_r      <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Output flops, all active low except o_upper_is_x8
    // ---------------------------------------------------------------
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            // Reset: pins released, pullups hold them high
            o_peripheral_select_n      <= 8'hff;
            o_peripheral_select_oe_n   <= 1'b1;
            o_upper_memory_select_n    <= 1'b1;
            o_upper_memory_select_oe_n <= 1'b1;
            o_row_strobe_upper_n       <= 1'b1;
            o_lower_memory_select_n    <= 1'b1;
            o_lower_select_oe_n        <= 1'b1;
            o_column_strobe_n          <= 2'h3;
            o_column_strobe_oe_n       <= 1'b1;
            o_upper_is_x8              <= 1'b0;
        end else if (hold_s) begin
            // Bus hold: release every pin with an enable; row strobe held high
            // Release lags the pin by three edges: two sync stages, this flop
            o_peripheral_select_n      <= 8'hff;
            o_peripheral_select_oe_n   <= 1'b1;
            o_upper_memory_select_n    <= 1'b1;
            o_upper_memory_select_oe_n <= 1'b1;
            o_row_strobe_upper_n       <= 1'b1;
            o_lower_memory_select_n    <= 1'b1;
            o_lower_select_oe_n        <= 1'b1;
            o_column_strobe_n          <= 2'h3;
            o_column_strobe_oe_n       <= 1'b1;
            o_upper_is_x8              <= upr_x8_r;
        end else begin
            // Driving: enables low, levels from the latched cycle
            o_peripheral_select_oe_n   <= 1'b0;
            o_upper_memory_select_oe_n <= 1'b0;
            o_lower_select_oe_n        <= 1'b0;
            o_column_strobe_oe_n       <= 1'b0;
            o_upper_is_x8              <= upr_x8_r;
            // Peripheral select one-hot, only in the data phase
            o_peripheral_select_n <= (per_act_r && i_data_phase) ?
                                     ~(8'h01 << per_idx_r) : 8'hff;
            // Upper: select in SRAM mode, upper row strobe in DRAM mode
            // Row strobe has no enable of its own; it idles high
            o_upper_memory_select_n <= !(upr_act_r && !upr_dram_r);
            o_row_strobe_upper_n    <= !(upr_act_r && upr_dram_r);
            // Lower pin carries select or lower row strobe
            o_lower_memory_select_n <= !lwr_act_r;
            // Column strobes wait for the data phase, not the row; byte lanes on writes
            if ((upr_act_r && upr_dram_r) || (lwr_act_r && lwr_dram_r)) begin
                // Reads strobe both lanes so the DRAM returns a full word
                if (i_data_phase && rd_r) begin
                    o_column_strobe_n <= 2'h0;
                end else if (i_data_phase) begin
                    o_column_strobe_n <= ~byte_r;
                end else begin
                    o_column_strobe_n <= 2'h3;
                end
            end else begin
                o_column_strobe_n <= 2'h3;
            end
        end
    end
endmodule
`default_nettype wire

/* File: hdl/csd_consts.vh */
// Purpose: constants for the chip-select and DRAM strobe block
// Assumes: 20-bit byte addresses, 16-bit I/O addresses, 40 MHz clock
// Notes:   offsets, fields, upper and peripheral reset values and counts live here
// Operation
// - Eight peripheral selects decode peripheral block
// - Peripheral block base set by software
// - Peripheral selects float in reset, hold
// - Peripheral at data phase, memory at address
// - Upper select on upper block, up 512K
// - Upper select floats in reset, hold
// - Upper width from strap sampled at reset
// - After reset upper window F0000h, 64K
// - Two column strobes when region is DRAM
// - Column strobe 0 low byte, 1 high
// - Upper DRAM uses upper row strobe
// - Lower DRAM uses row strobe on lower pin
// - Lower block base, size up to 512K
`ifndef CSD_CONSTS_VH
`define CSD_CONSTS_VH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define CSD_REG_PER_BASE  4'h0
`define CSD_REG_PER_CTRL  4'h1
`define CSD_REG_UPR_BASE  4'h2
`define CSD_REG_UPR_SIZE  4'h3
`define CSD_REG_LWR_BASE  4'h4
`define CSD_REG_LWR_SIZE  4'h5
`define CSD_REG_MEM_CTRL  4'h6
`define CSD_REG_STATUS    4'h7
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CSD_PER_MEM_BIT   0
`define CSD_UPR_DRAM_BIT  0
`define CSD_LWR_DRAM_BIT  1
`define CSD_UPR_X8_BIT    2
`define CSD_LWR_EN_BIT    3
// ---------------------------------------------------------------
// Reset values (upper base and size in 4K units, 8 bits wide)
// ---------------------------------------------------------------
`define CSD_UPR_BASE_RST  8'hf0
`define CSD_UPR_SIZE_RST  8'h10
`define CSD_MAX_SIZE      8'h80
`define CSD_PER_BASE_RST  16'h0000
`define CSD_PER_SHIFT     7
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CSD_CYC_PER_PHASE 2'h1
`endif

/* File: hdl/csd_sync.v */
// Purpose: two-stage synchroniser for one pin level
// Assumes: the input is asynchronous to i_clk
// Notes:   the first stage is read only by the second
`default_nettype none
module csd_sync (
    // Clock and reset
    input  wire i_clk,
    input  wire i_nrst,
    // Pin level
    input  wire i_d,
    output reg  o_q
);
    reg meta_r;   // First stage, feeds o_q only

    // ---------------------------------------------------------------
    // Two flops in series
    // ---------------------------------------------------------------
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_r <= 1'b0;
            o_q    <= 1'b0;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/csd_monitor.sv */
// Purpose: concurrent checks on select and strobe pins
// Assumes: bench drives bus hold in step with i_clk
// Notes:   sees top-level ports only, bound below
`default_nettype none
module csd_monitor (
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_addr_valid,
    input wire logic        i_data_phase,
    input wire logic        i_bus_hold,
    input wire logic        i_reg_rd,
    input wire logic [15:0] o_reg_rdata,
    input wire logic [7:0]  o_peripheral_select_n,
    input wire logic        o_peripheral_select_oe_n,
    input wire logic        o_upper_memory_select_n,
    input wire logic        o_upper_memory_select_oe_n,
    input wire logic        o_row_strobe_upper_n,
    input wire logic        o_lower_memory_select_n,
    input wire logic        o_lower_select_oe_n,
    input wire logic [1:0]  o_column_strobe_n,
    input wire logic        o_column_strobe_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    wire idle_all = &{o_peripheral_select_n, o_upper_memory_select_n, o_row_strobe_upper_n,
                      o_lower_memory_select_n, o_column_strobe_n};
    wire oe_all   = &{o_peripheral_select_oe_n, o_upper_memory_select_oe_n,
                      o_lower_select_oe_n, o_column_strobe_oe_n};
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    property p_hold_float; i_bus_hold [*4] |-> oe_all && idle_all; endproperty
    a_hold_float: assert property (p_hold_float) else $error("pins not released in hold");
    property p_pcs_onehot; $onehot0(~o_peripheral_select_n); endproperty
    a_pcs_onehot: assert property (p_pcs_onehot) else $error("two peripheral selects low");
    property p_pcs_phase; !(&o_peripheral_select_n) |-> $past(i_data_phase); endproperty
    a_pcs_phase: assert property (p_pcs_phase) else $error("peripheral select before data phase");
    property p_upr_early; $fell(o_upper_memory_select_n) |-> $past(i_addr_valid, 2); endproperty
    a_upr_early: assert property (p_upr_early) else $error("upper select off address timing");
    property p_ras_upr; $fell(o_row_strobe_upper_n) |-> $past(i_addr_valid, 2); endproperty
    a_ras_upr: assert property (p_ras_upr) else $error("upper row strobe mistimed");
    property p_lwr; $fell(o_lower_memory_select_n) |-> $past(i_addr_valid, 2); endproperty
    a_lwr: assert property (p_lwr) else $error("lower pin mistimed");
    property p_cas;
        ($fell(o_column_strobe_n[0]) || $fell(o_column_strobe_n[1])) |-> $past(i_data_phase);
    endproperty
    a_cas: assert property (p_cas) else $error("column strobe before data phase");
    property p_drive; !o_upper_memory_select_n |-> !o_upper_memory_select_oe_n; endproperty
    a_drive: assert property (p_drive) else $error("upper select low but released");
    property p_idle; (!i_addr_valid && !i_data_phase) [*4] |-> idle_all; endproperty
    a_idle: assert property (p_idle) else $error("strobe low with no bus cycle");
    property p_rdata; !$past(i_reg_rd) |-> o_reg_rdata == 16'h0000; endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
endmodule
bind csd_top csd_monitor u_mon (.*);
`default_nettype wire

/* File: testbench/csd_pin_model.sv */
// Purpose: board side of the select pins: pullups on released pins
// Assumes: oe_n low means the block drives the pin
// Notes:   attached devices only observe the resolved levels
`default_nettype none
module csd_pin_model (
    // Pins from the block
    input  wire logic [7:0] i_pcs_n,
    input  wire logic       i_pcs_oe_n,
    input  wire logic       i_ums_n,
    input  wire logic       i_ums_oe_n,
    input  wire logic       i_lwr_n,
    input  wire logic       i_lwr_oe_n,
    input  wire logic [1:0] i_cas_n,
    input  wire logic       i_cas_oe_n,
    // Levels seen by memories and peripherals
    output wire logic [7:0] o_pcs,
    output wire logic       o_ums,
    output wire logic       o_lwr,
    output wire logic [1:0] o_cas
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released pins rise to the pullup, never keep the last level
    assign o_pcs = i_pcs_oe_n ? 8'hff : i_pcs_n;
    assign o_ums = i_ums_oe_n ? 1'b1 : i_ums_n; // Weak pullup only
    assign o_lwr = i_lwr_oe_n ? 1'b1 : i_lwr_n;
    assign o_cas = i_cas_oe_n ? 2'h3 : i_cas_n;
endmodule
`default_nettype wire

/* File: testbench/csd_tb_top.sv */
// Purpose: random and corner tests of selects and DRAM strobes
// Assumes: register map and bus timing as handed over
// Notes:   expectations built from address arithmetic only
`include "csd_consts.vh"
`default_nettype none
module csd_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 1'b0, i_nrst = 1'b0, av = 0, dp = 0, mem = 0, wl = 0, wh = 0, rd = 0, hold = 0, strap = 0;
    logic rw = 0, rr = 0;
    logic [19:0] adr = 0, pa;
    logic [3:0]  ra = 0;
    logic [15:0] wd = 0, rdata, base;
    logic [7:0]  pcs_n, pcs;
    logic [1:0]  cas_n, cas;
    logic pcs_oe, ums_n, ums_oe, ras_n, lwr_n, lwr_oe, cas_oe, x8, ums, lwr;
    integer seed, err_total = 0, n_checks = 0, m, n;
    csd_top uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr_valid(av), .i_data_phase(dp), .i_is_mem(mem),
        .i_addr(adr), .i_write_low_byte(wl), .i_write_high_byte(wh), .i_read(rd), .i_bus_hold(hold),
        .i_upper_select_byte_width_strap(strap), .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(rw),
        .i_reg_rd(rr), .o_reg_rdata(rdata), .o_peripheral_select_n(pcs_n), .o_peripheral_select_oe_n(pcs_oe),
        .o_upper_memory_select_n(ums_n), .o_upper_memory_select_oe_n(ums_oe), .o_row_strobe_upper_n(ras_n),
        .o_lower_memory_select_n(lwr_n), .o_lower_select_oe_n(lwr_oe), .o_column_strobe_n(cas_n),
        .o_column_strobe_oe_n(cas_oe), .o_upper_is_x8(x8));
    csd_pin_model u_pins (.i_pcs_n(pcs_n), .i_pcs_oe_n(pcs_oe), .i_ums_n(ums_n), .i_ums_oe_n(ums_oe),
        .i_lwr_n(lwr_n), .i_lwr_oe_n(lwr_oe), .i_cas_n(cas_n), .i_cas_oe_n(cas_oe),
        .o_pcs(pcs), .o_ums(ums), .o_lwr(lwr), .o_cas(cas));
    // ------------------------------------------------
    // Clock, watchdog and shared tasks
    // ------------------------------------------------
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        #1000000;
        err_total = err_total + 1;
        conclude();
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Reset for four edges; pins checked released once, after the third edge
    task automatic reset(input logic s);
        @(posedge i_clk);
        i_nrst <= 1'b0;
        strap <= s;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        check({pcs_oe, ums_oe, lwr_oe, cas_oe, ums, lwr, ras_n, pcs}, 16'h7fff);
        @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (4) @(posedge i_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        ra <= a;
        wd <= d;
        rw <= 1'b1;
        @(posedge i_clk);
        rw <= 1'b0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        ra <= a;
        rr <= 1'b1;
        @(posedge i_clk);
        rr <= 1'b0;
        @(negedge i_clk);
        check(rdata, exp);
    endtask
    // One bus cycle; e packs {upper, row upper, lower pin, column[1:0]}
    task automatic bus(input logic mm, input logic [19:0] a, input logic [1:0] w,
                       input logic [7:0] ep, input logic [4:0] e, input logic [4:0] mk);
        @(posedge i_clk);
        av <= 1'b1;
        mem <= mm;
        adr <= a;
        {wh, wl} <= w;
        rd <= (w == 2'h0);
        @(posedge i_clk);
        av <= 1'b0;
        adr <= ~a; // Address is sampled with the valid pulse only
        dp <= 1'b1;
        @(posedge i_clk);
        @(negedge i_clk);
        check({8'h00, pcs}, {8'h00, ep});
        check({11'h000, {ums, ras_n, lwr, cas} & mk}, {11'h000, e & mk});
        @(posedge i_clk);
        dp <= 1'b0;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        check({3'h0, ums, ras_n, lwr, cas, pcs}, 16'h1fff);
    endtask
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        seed = 60126;
        reset(1'b0);
        rdchk(`CSD_REG_UPR_BASE, 16'h00f0);
        rdchk(`CSD_REG_UPR_SIZE, 16'h0010);
        rdchk(4'h9, 16'h0000);
        bus(1, 20'hffff0, 2'h0, 8'hff, 5'h0f, 5'h1f);
        check({15'h0000, x8}, 16'h0000);
        bus(1, 20'hf0000, 2'h3, 8'hff, 5'h0f, 5'h1f);
        bus(1, 20'hefffe, 2'h3, 8'hff, 5'h1f, 5'h1f);
        bus(0, 20'hffff0, 2'h0, 8'hff, 5'h1f, 5'h1f);
        repeat (4) bus(1, {4'hf, 16'($random(seed))}, 2'h1, 8'hff, 5'h0f, 5'h1f);
        // Peripheral block in I/O, then memory space, random base
        for (m = 0; m < 2; m = m + 1) begin
            base = 16'($random(seed)) & 16'h0c00;
            wr(`CSD_REG_PER_CTRL, 16'(m));
            wr(`CSD_REG_PER_BASE, base);
            rdchk(`CSD_REG_PER_BASE, base);
            for (n = 0; n < 8; n = n + 1) begin
                pa = (m ? {base, 4'h0} : {4'h0, base}) + 20'(n * 128) + (20'($random(seed)) & 20'h0007f);
                bus(m[0], pa, 2'h3, ~(8'h01 << n), 5'h1f, 5'h1f);
            end
            bus(m[0], (m ? {base, 4'h0} : {4'h0, base}) + 20'h00400, 2'h0, 8'hff, 5'h1f, 5'h1f);
        end
        // Oversized upper block is cut to 512K in the decode: 40000h..BFFFFh
        wr(`CSD_REG_UPR_SIZE, 16'h00ff);
        rdchk(`CSD_REG_UPR_SIZE, 16'h00ff);
        wr(`CSD_REG_UPR_BASE, 16'h0040);
        bus(1, 20'hbfffe, 2'h0, 8'hff, 5'h0f, 5'h1f);
        bus(1, 20'hc0000, 2'h0, 8'hff, 5'h1f, 5'h1f);
        // Lower block 10000h..2FFFFh as plain select, then DRAM
        wr(`CSD_REG_LWR_BASE, 16'h0010);
        wr(`CSD_REG_LWR_SIZE, 16'h0020);
        wr(`CSD_REG_MEM_CTRL, 16'h0008);
        bus(1, 20'h10000, 2'h3, 8'hff, 5'h1b, 5'h1f);
        bus(1, 20'h2fffe, 2'h0, 8'hff, 5'h1b, 5'h1f);
        bus(1, 20'h30000, 2'h0, 8'hff, 5'h1f, 5'h1f);
        wr(`CSD_REG_MEM_CTRL, 16'h000a);
        for (n = 0; n < 4; n = n + 1)
            bus(1, 20'h20000, 2'(n), 8'hff, {3'h6, (n == 0) ? 2'h0 : ~2'(n)}, 5'h1f);
        // Upper block as DRAM; select pin must stay high here
        wr(`CSD_REG_MEM_CTRL, 16'h0009);
        for (n = 0; n < 4; n = n + 1)
            bus(1, 20'h90000, 2'(n), 8'hff, {3'h5, (n == 0) ? 2'h0 : ~2'(n)}, 5'h1f);
        // Bus hold releases every pin with an enable, accesses go unseen
        @(posedge i_clk);
        hold <= 1'b1;
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        check({12'h000, pcs_oe, ums_oe, lwr_oe, cas_oe}, 16'h000f);
        bus(1, 20'h90000, 2'h3, 8'hff, 5'h1f, 5'h1f);
        @(posedge i_clk);
        hold <= 1'b0;
        repeat (4) @(posedge i_clk);
        // Second reset with the 8-bit strap restores the boot window
        reset(1'b1);
        bus(1, 20'hffff0, 2'h0, 8'hff, 5'h0f, 5'h1f);
        check({15'h0000, x8}, 16'h0001);
        conclude();
    end
endmodule
`default_nettype wire
